// *** core/resampler_discriminator_ctrl.sv ***
// control top of the resampler and frequency discriminator back end:
// register port, strobe transfers to active timing registers, resampler
// path selection and extra output timing, discriminator configuration.
// assumes a host that writes registers synchronous to ref_clk.
//
// Behaviour
// [R1] frequency strobe write copies held frequency
// [R2] phase strobe write copies held phase
// [R3] extra outputs spaced by pulse delay field
// [R4] host never writes delay zero or one
// [R5] one extra by two, three by four
// [R6] host sets delay to clock over rate minus one
// [R7] host keeps delay at five or more
// [R8] delay under sixteen may cut serial output
// [R9] bypass skips whole resampler including halfbands
// [R10] mode code picks filters, some codes invalid
// [R11] phase shifted left zero to three, enable
// [R12] decimation code zero means eight
// [R13] tap count equals field, never zero
// [R14] difference delay is field plus one
// [R15] symmetry type and symmetry use select FIR form
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module resampler_discriminator_ctrl (
  input  wire logic        ref_clk,      // processing clock, 250 MHz
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire logic [3:0]  regAddr,      // register index
  input  wire logic [31:0] regWdata,     // write data
  input  wire logic        regWr,        // write strobe
  input  wire logic        regRd,        // read strobe
  output logic      [31:0] regRdata,     // read data, cycle after strobe
  input  wire logic        sampleIn,     // new resampler input sample
  input  wire logic [15:0] phaseIn,      // converter phase word
  output logic             outStrobe,    // resampler output strobe
  output logic      [31:0] activeFreq,   // active timing frequency
  output logic      [7:0]  activePhase,  // active timing phase offset
  output logic             bypassPath,   // resampler section bypassed
  output logic             resampEn,     // resampler filter in path
  output logic             firstHbEn,    // first_interp_halfband in path
  output logic             secondHbEn,   // second_interp_halfband in path
  output logic             modeInvalid,  // mode code not usable
  output logic             serialRisk,   // delay may cut serial output
  output logic      [15:0] discPhase,    // shifted phase to discriminator
  output logic             discEn,       // discriminator enable
  output logic      [3:0]  firDecim,     // FIR decimation 1 to 8
  output logic             firEvenSym,   // even symmetry selected
  output logic             firAsym,      // coefficients asymmetric
  output logic      [5:0]  firTaps,      // FIR tap count
  output logic      [3:0]  diffDelay     // differencing delay 1 to 8
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // true for the mode codes that select a real filter chain
  function automatic logic mode_ok(input logic [2:0] m);
    begin
      case (m)
        resamp_disc_pkg::MODE_RESAMP,
        resamp_disc_pkg::MODE_HB1,
        resamp_disc_pkg::MODE_RESAMP_HB1,
        resamp_disc_pkg::MODE_HB12,
        resamp_disc_pkg::MODE_ALL: mode_ok = 1'b1;
        default:                   mode_ok = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] holdFreq_r;   // held timing frequency
  logic [7:0]  holdPhase_r;  // held timing phase
  logic [31:0] actFreq_r;    // active timing frequency
  logic [7:0]  actPhase_r;   // active timing phase
  logic [11:0] rsCtrl_r;     // resampling filter control
  logic [16:0] dcCtrl_r;     // discriminator control
  logic [31:0] rdata_r;      // read data register
  logic [15:0] discPhase_r;  // shifted phase register
  logic        wrHit;        // helper for decode

  // every write is taken in the clock that carries the strobe; the host
  // never waits, so there is no ready signal on this port
  assign wrHit = regWr;

  // held words written by the host
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      holdFreq_r  <= resamp_disc_pkg::FREQ_RST;
      holdPhase_r <= resamp_disc_pkg::PHASE_RST;
    end else if (wrHit && regAddr == resamp_disc_pkg::IDX_FREQ_HOLD) begin
      holdFreq_r  <= regWdata;
    end else if (wrHit && regAddr == resamp_disc_pkg::IDX_PHASE_HOLD) begin
      holdPhase_r <= regWdata[7:0];
    end
  end

  // strobe writes move held values to active, data ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      actFreq_r  <= resamp_disc_pkg::FREQ_RST;
      actPhase_r <= resamp_disc_pkg::PHASE_RST;
    end else begin
      if (wrHit && regAddr == resamp_disc_pkg::IDX_FREQ_STROBE) begin
        actFreq_r <= holdFreq_r;  // see [R1]
      end
      if (wrHit && regAddr == resamp_disc_pkg::IDX_PHASE_STROBE) begin
        actPhase_r <= holdPhase_r;  // see [R2]
      end
    end
  end

  // configuration words, reserved bits dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsCtrl_r <= resamp_disc_pkg::RS_CTRL_RST;
      dcCtrl_r <= resamp_disc_pkg::DC_CTRL_RST;
    end else if (wrHit && regAddr == resamp_disc_pkg::IDX_RESAMP_CTRL) begin
      rsCtrl_r <= regWdata[11:0];
    end else if (wrHit && regAddr == resamp_disc_pkg::IDX_DISC_CTRL) begin
      dcCtrl_r <= regWdata[16:0];
    end
  end

  // ---------------------------------------------------------------
  // resampler path
  // ---------------------------------------------------------------
  logic [2:0] modeCode;  // filter mode field
  logic [7:0] pulseDly;  // output pulse delay field
  logic       bypassBit; // bypass field

  assign modeCode  = rsCtrl_r[resamp_disc_pkg::RS_MODE_LSB +: resamp_disc_pkg::RS_MODE_W];
  assign pulseDly  = rsCtrl_r[resamp_disc_pkg::RS_DELAY_LSB +: resamp_disc_pkg::RS_DELAY_W];
  assign bypassBit = rsCtrl_r[resamp_disc_pkg::RS_BYPASS_BIT];

  // bypass overrides every filter, halfbands included
  assign bypassPath  = bypassBit;                          // see [R9]
  assign modeInvalid = !bypassBit && !mode_ok(modeCode);   // see [R9] see [R10]
  assign resampEn    = !bypassPath && !modeInvalid && modeCode[0]; // see [R10]
  assign firstHbEn   = !bypassPath && !modeInvalid && modeCode[1]; // see [R10]
  assign secondHbEn  = !bypassPath && !modeInvalid && modeCode[2]; // see [R10]
  // short spacing warning for the serial output
  assign serialRisk  = !bypassPath && (pulseDly < resamp_disc_pkg::SERIAL_SAFE_DLY); // see [R8]

  pulse_cfg_if pcfg ();

  // extra outputs: one when by two, three when by four
  always_comb begin
    if (bypassPath || modeInvalid) begin
      pcfg.extraCount = 2'h0;
    end else if (secondHbEn) begin
      pcfg.extraCount = resamp_disc_pkg::EXTRA_BY4;  // see [R5]
    end else if (firstHbEn) begin
      pcfg.extraCount = resamp_disc_pkg::EXTRA_BY2;  // see [R5]
    end else begin
      pcfg.extraCount = 2'h0;
    end
  end
  assign pcfg.sampleIn   = sampleIn;
  assign pcfg.pulseDelay = pulseDly;  // see [R3]

  extra_pulse_gen u_pulse (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cfg     (pcfg)
  );

  // first output follows the sample, extras from the spacer
  assign outStrobe = sampleIn || pcfg.extraPulse;

  // ---------------------------------------------------------------
  // discriminator
  // ---------------------------------------------------------------
  logic [1:0] multSel;  // phase multiplier field

  assign multSel = dcCtrl_r[resamp_disc_pkg::DC_MULT_LSB +: resamp_disc_pkg::DC_MULT_W];

  // shift up, top bits dropped, zero fill from the bottom
  // the phase is modulo a full circle, so losing the top bits is exactly
  // the wrap that the multiplier needs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      discPhase_r <= 16'h0000;
    end else begin
      discPhase_r <= phaseIn << multSel;  // see [R11]
    end
  end
  assign discPhase  = discPhase_r;
  assign discEn     = dcCtrl_r[resamp_disc_pkg::DC_EN_BIT];  // see [R11]
  // code zero decimates by eight
  assign firDecim   = (dcCtrl_r[13:11] == 3'h0) ? resamp_disc_pkg::DEC_BY8
                                                : {1'b0, dcCtrl_r[13:11]};  // see [R12]
  assign firEvenSym = dcCtrl_r[resamp_disc_pkg::DC_SYMT_BIT];  // see [R15]
  assign firAsym    = dcCtrl_r[resamp_disc_pkg::DC_SYM_BIT];   // see [R15]
  assign firTaps    = dcCtrl_r[resamp_disc_pkg::DC_TAPS_LSB +: resamp_disc_pkg::DC_TAPS_W]; // see [R13]
  assign diffDelay  = {1'b0, dcCtrl_r[2:0]} + 4'h1;  // see [R14]

  assign activeFreq  = actFreq_r;
  assign activePhase = actPhase_r;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // read data valid only in the cycle after the strobe; strobes read zero
  // the strobe locations hold nothing of their own, so reading them is harmless
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        resamp_disc_pkg::IDX_RESAMP_CTRL: rdata_r <= {20'h00000, rsCtrl_r};
        resamp_disc_pkg::IDX_DISC_CTRL:   rdata_r <= {15'h0000, dcCtrl_r};
        resamp_disc_pkg::IDX_FREQ_HOLD:   rdata_r <= holdFreq_r;
        resamp_disc_pkg::IDX_PHASE_HOLD:  rdata_r <= {24'h000000, holdPhase_r};
        resamp_disc_pkg::IDX_STATUS:      rdata_r <= {28'h0000000, pcfg.busy,
                                                      serialRisk, modeInvalid,
                                                      bypassPath};
        default:                          rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end
  assign regRdata = rdata_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence freq_strobe_s;
    regWr && regAddr == resamp_disc_pkg::IDX_FREQ_STROBE;
  endsequence

  chk_freq_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R1]
    freq_strobe_s |=> activeFreq == $past(holdFreq_r))
    else $error("frequency strobe did not copy held value");

  chk_phase_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R2]
    regWr && regAddr == resamp_disc_pkg::IDX_PHASE_STROBE
    |=> activePhase == $past(holdPhase_r))
    else $error("phase strobe did not copy held value");

  chk_extra_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R3]
    pcfg.extraPulse && pcfg.busy |-> !$past(pcfg.extraPulse))
    else $error("extra outputs too close");

  chk_by2_extra: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R5]
    firstHbEn && !secondHbEn |-> pcfg.extraCount == 2'h1)
    else $error("by two should give one extra output");

  chk_bypass_all: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R9]
    bypassPath |-> !resampEn && !firstHbEn && !secondHbEn)
    else $error("bypass left a filter in the path");

  chk_mode_invalid: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R10]
    !bypassPath && modeCode == 3'h4 |-> modeInvalid)
    else $error("code 100 not flagged invalid");

  chk_phase_shift: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R11]
    $stable(multSel) |=> discPhase == 16'($past(phaseIn) << $past(multSel)))
    else $error("phase shift wrong");

  chk_decim_eight: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    dcCtrl_r[13:11] == 3'h0 |-> firDecim == 4'h8)
    else $error("code zero must decimate by eight");

  chk_diff_delay: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R14]
    diffDelay != 4'h0 && diffDelay <= 4'h8 &&
    (dcCtrl_r[2:0] != 3'h7 || diffDelay == 4'h8))
    else $error("differencing delay wrong");

  // first extra output of a by-two or by-four sample at a delay of five:
  // the spacer counts from the clock that takes the input sample
  sequence start_d5_s;
    sampleIn && pcfg.extraCount != 2'h0 && pulseDly == 8'h05;
  endsequence

  // five quiet clocks with no new sample and the delay left alone
  sequence quiet_d5_s;
    (!sampleIn && pulseDly == 8'h05) [*5];
  endsequence

  chk_first_extra: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R3]
    start_d5_s ##1 quiet_d5_s |=> pcfg.extraPulse)
    else $error("first extra output not one clock past the delay");

  chk_by4_extra: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R5]
    secondHbEn |-> pcfg.extraCount == 2'h3)
    else $error("by four should give three extra outputs");

  chk_serial_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R8]
    !bypassPath && pulseDly < 8'h10 |-> serialRisk)
    else $error("short pulse delay not flagged");

  // active values move only on their strobes
  chk_freq_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R1]
    !(regWr && regAddr == resamp_disc_pkg::IDX_FREQ_STROBE) |=> $stable(activeFreq))
    else $error("active frequency moved without a strobe");

  chk_phase_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R2]
    !(regWr && regAddr == resamp_disc_pkg::IDX_PHASE_STROBE) |=> $stable(activePhase))
    else $error("active phase moved without a strobe");

  chk_decim_range: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    firDecim != 4'h0 && firDecim <= 4'h8)
    else $error("decimation outside one to eight");

endmodule
`default_nettype wire

// *** shared/resamp_disc_pkg.sv ***
// package: register map, field layout and constants of the resampler and
// discriminator control block.
// assumes a plain register port with word indices as addresses.
package resamp_disc_pkg;

  // register indices (one word each, byte address is four times the index)
  localparam logic [3:0] IDX_FREQ_STROBE  = 4'he;
  localparam logic [3:0] IDX_PHASE_STROBE = 4'hf;
  localparam logic [3:0] IDX_RESAMP_CTRL  = 4'h0;
  localparam logic [3:0] IDX_DISC_CTRL    = 4'h1;
  localparam logic [3:0] IDX_FREQ_HOLD    = 4'hc;
  localparam logic [3:0] IDX_PHASE_HOLD   = 4'hd;
  localparam logic [3:0] IDX_STATUS       = 4'h2;
  localparam int         ADDR_W           = 4;

  // resampling filter control fields
  localparam int RS_DELAY_LSB  = 4;
  localparam int RS_DELAY_W    = 8;
  localparam int RS_BYPASS_BIT = 3;
  localparam int RS_MODE_LSB   = 0;
  localparam int RS_MODE_W     = 3;
  localparam int RS_USED_W     = 12;

  // discriminator control fields
  localparam int DC_MULT_LSB   = 15;
  localparam int DC_MULT_W     = 2;
  localparam int DC_EN_BIT     = 14;
  localparam int DC_DEC_LSB    = 11;
  localparam int DC_DEC_W      = 3;
  localparam int DC_SYMT_BIT   = 10;
  localparam int DC_SYM_BIT    = 9;
  localparam int DC_TAPS_LSB   = 3;
  localparam int DC_TAPS_W     = 6;
  localparam int DC_DLY_LSB    = 0;
  localparam int DC_DLY_W      = 3;
  localparam int DC_USED_W     = 17;

  // reset values
  localparam logic [11:0] RS_CTRL_RST   = 12'h059; // delay 5, bypass on, mode 001
  localparam logic [16:0] DC_CTRL_RST   = 17'h00008; // one tap, all else zero
  localparam logic [31:0] FREQ_RST      = 32'h0000_0000;
  localparam logic [7:0]  PHASE_RST     = 8'h00;

  // filter mode codes
  localparam logic [2:0] MODE_RESAMP    = 3'h1;
  localparam logic [2:0] MODE_HB1       = 3'h2;
  localparam logic [2:0] MODE_RESAMP_HB1 = 3'h3;
  localparam logic [2:0] MODE_HB12      = 3'h6;
  localparam logic [2:0] MODE_ALL       = 3'h7;

  // interpolation factors and limits
  localparam logic [1:0] EXTRA_BY2      = 2'h1;
  localparam logic [1:0] EXTRA_BY4      = 2'h3;
  localparam logic [7:0] SERIAL_SAFE_DLY = 8'h10;
  localparam logic [3:0] DEC_BY8        = 4'h8;

  // pulse generator states
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_WAIT = 2'b01,
    PG_EMIT = 2'b10
  } pulse_state_t;

endpackage

// *** shared/pulse_cfg_if.sv ***
// interface: configuration and event signals between the control top and
// its extra-output pulse spacer.
// assumes both ends on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface pulse_cfg_if;
  logic       sampleIn;   // first output of an input sample
  logic [7:0] pulseDelay; // output spacing minus one, in clocks
  logic [1:0] extraCount; // extra outputs per input, zero when none
  logic       extraPulse; // one extra output strobe
  logic       busy;       // extra outputs still pending
  modport ctrl (output sampleIn, output pulseDelay, output extraCount,
                input extraPulse, input busy);
  modport gen (input sampleIn, input pulseDelay, input extraCount,
               output extraPulse, output busy);
endinterface
`default_nettype wire

// *** core/extra_pulse_gen.sv ***
// extra output pulse spacer: after a first output, emits one, or three,
// further output strobes each spaced by the programmed delay plus one clock.
// assumes a delay of at least 2 clocks and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module extra_pulse_gen (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  pulse_cfg_if.gen   cfg
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  resamp_disc_pkg::pulse_state_t state_r;  // spacer state
  logic [7:0]                    count_r;  // clocks since last output
  logic [1:0]                    left_r;   // extra outputs still owed

  // walk through the spacing; a new sample restarts the sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= resamp_disc_pkg::PG_IDLE;
      count_r <= 8'h00;
      left_r  <= 2'h0;
    end else if (cfg.sampleIn && cfg.extraCount != 2'h0) begin
      state_r <= resamp_disc_pkg::PG_WAIT;
      count_r <= 8'h01;
      left_r  <= cfg.extraCount;
    end else begin
      case (state_r)
        resamp_disc_pkg::PG_IDLE: begin
          count_r <= 8'h00;
        end
        resamp_disc_pkg::PG_WAIT: begin
          // spacing counted from the previous output (see [R3])
          if (count_r >= cfg.pulseDelay) begin
            state_r <= resamp_disc_pkg::PG_EMIT;
          end else begin
            count_r <= count_r + 8'h01;
          end
        end
        resamp_disc_pkg::PG_EMIT: begin
          left_r  <= left_r - 2'h1;
          count_r <= 8'h01;
          state_r <= (left_r == 2'h1) ? resamp_disc_pkg::PG_IDLE
                                      : resamp_disc_pkg::PG_WAIT;
        end
        default: begin
          state_r <= resamp_disc_pkg::PG_IDLE;
        end
      endcase
    end
  end

  // the strobe itself is the emit state, output one cycle long
  assign cfg.extraPulse = (state_r == resamp_disc_pkg::PG_EMIT); // see [R3]
  assign cfg.busy       = (state_r != resamp_disc_pkg::PG_IDLE);

endmodule
`default_nettype wire

// *** bench/tb_resampler_discriminator_ctrl.sv ***
// testbench of the resampler and discriminator control block.
// assumes the package and interface are compiled first; one clock, no partner.
`timescale 1ns/1ps
`default_nettype none
module tb_resampler_discriminator_ctrl;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        ref_clk;     // processing clock
  logic        rst_n;       // synchronous reset, active low
  logic [3:0]  regAddr;     // register index
  logic [31:0] regWdata;    // write data
  logic        regWr;       // write strobe
  logic        regRd;       // read strobe
  logic        sampleIn;    // first output of an input sample
  logic [15:0] phaseIn;     // converter phase
  logic [31:0] regRdata;    // read data
  logic        outStrobe;   // output strobe
  logic [31:0] activeFreq;  // active frequency
  logic [7:0]  activePhase; // active phase offset
  logic        bypassPath, resampEn, firstHbEn, secondHbEn, modeInvalid, serialRisk;
  logic [15:0] discPhase;   // shifted phase
  logic        discEn, firEvenSym, firAsym;
  logic [3:0]  firDecim, diffDelay;
  logic [5:0]  firTaps;
  int          nFail;       // mismatches
  int          nChecks;     // comparisons
  logic [31:0] w, h, rdv;   // scratch words
  logic [7:0]  pw;          // phase expected before its strobe
  logic [3:0]  mf;          // expected filter flags of a mode

  resampler_discriminator_ctrl u_resampler_discriminator_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sampleIn(sampleIn),
    .phaseIn(phaseIn), .outStrobe(outStrobe), .activeFreq(activeFreq),
    .activePhase(activePhase), .bypassPath(bypassPath), .resampEn(resampEn),
    .firstHbEn(firstHbEn), .secondHbEn(secondHbEn), .modeInvalid(modeInvalid),
    .serialRisk(serialRisk), .discPhase(discPhase), .discEn(discEn),
    .firDecim(firDecim), .firEvenSym(firEvenSym), .firAsym(firAsym),
    .firTaps(firTaps), .diffDelay(diffDelay));

  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk; // 250 MHz
  end

  // compare and count, report at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // one-cycle read, data sampled in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // filter flags {resamp, hb1, hb2, invalid} of a mode code
  function automatic logic [3:0] modeFlags(input logic [2:0] m);
    if (m == 3'h0 || m == 3'h4 || m == 3'h5) return 4'h1;
    return {m[0], m[1], m[2], 1'b0};
  endfunction

  // extra outputs per input sample for a mode code
  function automatic int extraCount(input logic [2:0] m);
    if (modeFlags(m) == 4'h1) return 0;
    return m[2] ? 3 : (m[1] ? 1 : 0);
  endfunction

  // decimation for a code, zero means eight
  function automatic logic [3:0] expDecim(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : {1'b0, c};
  endfunction

  // closing report
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // extra-output spacing for one mode and delay
  task automatic pulseTest(input logic [2:0] m, input logic [7:0] d);
    int n;
    n = 0;
    wr(resamp_disc_pkg::IDX_RESAMP_CTRL, {20'h0, d, 1'b0, m});
    #1 chk("serialRisk", {31'h0, d < 8'h10}, {31'h0, serialRisk});
    @(posedge ref_clk);
    sampleIn <= 1'b1;
    @(negedge ref_clk);
    chk("first strobe", 32'h1, {31'h0, outStrobe});
    @(posedge ref_clk);
    sampleIn <= 1'b0;
    for (int t = 1; t <= 4 * (d + 1) + 4; t++) begin
      @(negedge ref_clk);
      if (outStrobe === 1'b1) begin
        n++;
        chk("extra time", n * (d + 1), t);
      end
    end
    chk("extra count", extraCount(m), n);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #400000;
    nFail++;
    wrapUp();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0; regAddr = 4'h0; regWdata = 32'h0; regWr = 1'b0;
    regRd = 1'b0; sampleIn = 1'b0; phaseIn = 16'h0; nFail = 0; nChecks = 0;
    void'($urandom(32000));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, unmapped and strobe reads
    rd(resamp_disc_pkg::IDX_RESAMP_CTRL, rdv);
    chk("resamp reset", {20'h0, resamp_disc_pkg::RS_CTRL_RST}, rdv);
    rd(resamp_disc_pkg::IDX_DISC_CTRL, rdv);
    chk("disc reset", {15'h0, resamp_disc_pkg::DC_CTRL_RST}, rdv);
    rd(4'h5, rdv);
    chk("unmapped read", 32'h0, rdv);
    rd(resamp_disc_pkg::IDX_FREQ_STROBE, rdv);
    chk("strobe read", 32'h0, rdv);
    // strobe transfers with random held values and random strobe data
    pw = resamp_disc_pkg::PHASE_RST;
    for (int i = 0; i < 8; i++) begin
      h = $urandom;
      w = $urandom;
      wr(resamp_disc_pkg::IDX_FREQ_HOLD, h);
      wr(resamp_disc_pkg::IDX_PHASE_HOLD, w);
      wr(resamp_disc_pkg::IDX_FREQ_STROBE, ~h);
      #1 chk("activeFreq", h, activeFreq);
      chk("phase waits", {24'h0, pw}, {24'h0, activePhase});
      wr(resamp_disc_pkg::IDX_PHASE_STROBE, $urandom);
      #1 chk("activePhase", {24'h0, w[7:0]}, {24'h0, activePhase});
      pw = w[7:0];
    end
    // every mode code, bypass clear then set
    for (int m = 0; m < 8; m++) begin
      mf = modeFlags(3'(m));
      wr(resamp_disc_pkg::IDX_RESAMP_CTRL, {20'h0, 8'h05, 1'b0, 3'(m)});
      #1 chk("mode flags", {28'h0, mf},
             {28'h0, resampEn, firstHbEn, secondHbEn, modeInvalid});
      chk("bypass clear", 32'h0, {31'h0, bypassPath});
      rd(resamp_disc_pkg::IDX_STATUS, rdv);
      chk("status", {28'h0, 1'b0, 1'b1, mf[0], 1'b0}, rdv);
      wr(resamp_disc_pkg::IDX_RESAMP_CTRL, {20'h0, 8'h05, 1'b1, 3'(m)});
      #1 chk("bypass set", 32'h1, {31'h0, bypassPath});
      chk("bypass filters", 32'h0, {29'h0, resampEn, firstHbEn, secondHbEn});
    end
    // extra output spacing at boundary and random delays
    pulseTest(resamp_disc_pkg::MODE_RESAMP_HB1, 8'h05);
    pulseTest(resamp_disc_pkg::MODE_ALL, 8'h05);
    pulseTest(resamp_disc_pkg::MODE_HB12, 8'h0f);
    pulseTest(resamp_disc_pkg::MODE_HB1, 8'h10);
    pulseTest(resamp_disc_pkg::MODE_ALL, 8'hff);
    pulseTest(resamp_disc_pkg::MODE_RESAMP, 8'h08);
    pulseTest(3'h4, 8'h06);
    pulseTest(resamp_disc_pkg::MODE_ALL, 8'h05 + 8'($urandom % 40));
    // discriminator configuration with random words
    for (int i = 0; i < 24; i++) begin
      w = $urandom;
      if (w[8:3] == 6'h0) w[8:3] = 6'h01;
      if (i < 8) w[13:11] = 3'(i);
      wr(resamp_disc_pkg::IDX_DISC_CTRL, w);
      h = $urandom;
      @(posedge ref_clk);
      phaseIn <= h[15:0];
      repeat (2) @(posedge ref_clk);
      #1 chk("discPhase", {16'h0, h[15:0] << w[16:15]}, {16'h0, discPhase});
      chk("discEn", {31'h0, w[14]}, {31'h0, discEn});
      chk("firDecim", {28'h0, expDecim(w[13:11])}, {28'h0, firDecim});
      chk("firEvenSym", {31'h0, w[10]}, {31'h0, firEvenSym});
      chk("firAsym", {31'h0, w[9]}, {31'h0, firAsym});
      chk("firTaps", {26'h0, w[8:3]}, {26'h0, firTaps});
      chk("diffDelay", {28'h0, 1'b0, w[2:0]} + 32'h1, {28'h0, diffDelay});
      rd(resamp_disc_pkg::IDX_DISC_CTRL, rdv);
      chk("disc readback", {15'h0, w[16:0]}, rdv);
    end
    // second reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(resamp_disc_pkg::IDX_RESAMP_CTRL, rdv);
    chk("resamp re-reset", {20'h0, resamp_disc_pkg::RS_CTRL_RST}, rdv);
    chk("freq re-reset", resamp_disc_pkg::FREQ_RST, activeFreq);
    wrapUp();
  end
endmodule
`default_nettype wire
